// file: tws_pkg.sv
// Constants and types shared by the three-wire serial port
package tws_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] TWS_MODE_CTRL_ADDR  = 16'hFFAF;
    localparam logic [15:0] TWS_SHIFT_DATA_ADDR = 16'hFFAE;
    localparam logic [7:0]  TWS_CTRL_RESET      = 8'h00;
    localparam logic [7:0]  TWS_CTRL_WMASK      = 8'h87;   // Bits 6..3 are fixed at zero
    localparam logic [7:0]  TWS_BLOCKED_READ    = 8'h00;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int unsigned TWS_ENABLE_POS  = 7;
    localparam int unsigned TWS_MODE_POS    = 2;
    localparam int unsigned TWS_CLKSEL_HI   = 1;
    localparam int unsigned TWS_CLKSEL_LO   = 0;

    // Clock select encodings
    localparam logic [1:0] TWS_CLK_EXTERNAL = 2'h0;
    localparam logic [1:0] TWS_CLK_DIV8     = 2'h1;
    localparam logic [1:0] TWS_CLK_DIV32    = 2'h2;
    localparam logic [1:0] TWS_CLK_DIV128   = 2'h3;

    // ************************************************************
    // Timing and sizes
    // ************************************************************
    localparam int unsigned TWS_RATIO_DIV8   = 8;
    localparam int unsigned TWS_RATIO_DIV32  = 32;
    localparam int unsigned TWS_RATIO_DIV128 = 128;
    localparam int unsigned TWS_DIV_W        = 6;
    localparam int unsigned TWS_WORD_BITS    = 8;
    localparam logic [2:0]  TWS_LAST_BIT     = 3'(TWS_WORD_BITS - 1);
    localparam int unsigned TWS_BUF_DEPTH    = 2;

    // Last divider count of each half period of the generated serial clock (half period in core cycles, less one)
    localparam logic [TWS_DIV_W-1:0] TWS_HALF_DIV8   = TWS_DIV_W'(TWS_RATIO_DIV8 / 2 - 1);
    localparam logic [TWS_DIV_W-1:0] TWS_HALF_DIV32  = TWS_DIV_W'(TWS_RATIO_DIV32 / 2 - 1);
    localparam logic [TWS_DIV_W-1:0] TWS_HALF_DIV128 = TWS_DIV_W'(TWS_RATIO_DIV128 / 2 - 1);

    // Transfer engine states
    typedef enum logic [1:0] {
        TWS_IDLE = 2'h0,
        TWS_RUN  = 2'h1
    } tws_state_t;

endpackage : tws_pkg

// file: tws_serial_port.sv
// Three-wire byte serial port with CPU register access and pin control
// How it works
// - Byte transfers over clock, output, input lines
// - Words always shift MSB first
// - Combined mode sends and captures together
// - Start needs enable bit and data access
// - Written byte goes out serially
// - Received bits assemble in shift register
// - Shift register resets to zero
// - Mode 0 blocks reads, 1 blocks writes
// - Mode control resets to zero
// - Mode control takes bit and byte writes
// - Disabled: stop, clear counter, release pins
// - Enabled: shifting and counting run
// - Mode selects trigger and output pin use
// - Two bits select external or divided clock
// - Shift and output on falling clock edge
// - Sample input on rising clock edge
// - Eight bits then stop and flag done
// - Write while disabled never starts transfer
module tws_serial_port
    import tws_pkg::*;
(
    // Core clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // CPU register access
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic        i_cpu_wr,
    input  wire logic        i_cpu_rd,
    input  wire logic [7:0]  i_cpu_wdata,
    input  wire logic        i_cpu_bit_wr,
    input  wire logic [2:0]  i_cpu_bit_idx,
    input  wire logic        i_cpu_bit_val,
    output logic      [7:0]  o_cpu_rdata,
    output logic             o_wr_ready,
    // Status towards the CPU
    output logic             o_transfer_done,
    output logic             o_busy,
    // Serial clock pin
    input  wire logic        i_sck_in,
    output logic             o_sck_out,
    output logic             o_sck_oe,
    // Serial data pins
    output logic             o_so_out,
    output logic             o_so_oe,
    input  wire logic        i_si_in
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]                   ctrl;
        logic [7:0]                   sreg;
        logic [7:0]                   rdata;
        logic                         so;
        tws_state_t                   state;
        logic [2:0]                   bitcnt;
        logic [TWS_DIV_W-1:0]         divcnt;
        logic                         sck_int;
        logic [2:0]                   sck_sync;
        logic                         sck_lvl;
        logic [2:0]                   si_sync;
        logic                         si_lvl;
        logic [TWS_BUF_DEPTH-1:0][7:0] buf_data;
        logic                         buf_wptr;
        logic                         buf_rptr;
        logic [1:0]                   buf_count;
        logic                         done;
    } tws_regs_t;

    tws_regs_t r_reg;
    tws_regs_t r_next;

    // Address decode used by several paths
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
        hit = (addr == target);
    endfunction

    // Last divider count of a half period for the selected divider
    function automatic logic [TWS_DIV_W-1:0] half_count(input logic [1:0] sel);
        unique case (sel)
            TWS_CLK_DIV8:   half_count = TWS_HALF_DIV8;
            TWS_CLK_DIV32:  half_count = TWS_HALF_DIV32;
            TWS_CLK_DIV128: half_count = TWS_HALF_DIV128;
            default:        half_count = TWS_HALF_DIV128;
        endcase
    endfunction

    // ************************************************************
    // Decoded control fields
    // ************************************************************
    logic       port_enable_bit;
    logic       rx_only_mode;
    logic [1:0] clock_select;
    logic       internal_clk;
    logic       ctrl_wr;
    logic       data_wr;
    logic       data_rd;
    logic       buf_full;

    assign port_enable_bit = r_reg.ctrl[TWS_ENABLE_POS];
    assign rx_only_mode    = r_reg.ctrl[TWS_MODE_POS];
    assign clock_select    = r_reg.ctrl[TWS_CLKSEL_HI:TWS_CLKSEL_LO];
    assign internal_clk    = (clock_select != TWS_CLK_EXTERNAL);
    assign ctrl_wr         = i_cpu_wr && hit(i_cpu_addr, TWS_MODE_CTRL_ADDR);
    assign data_wr         = i_cpu_wr && hit(i_cpu_addr, TWS_SHIFT_DATA_ADDR);
    assign data_rd         = i_cpu_rd && hit(i_cpu_addr, TWS_SHIFT_DATA_ADDR);
    assign buf_full        = (r_reg.buf_count == 2'(TWS_BUF_DEPTH));

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic ext_fall;
        logic ext_rise;
        logic sck_fall;
        logic sck_rise;
        logic push;
        logic pop;
        logic si_now;
        ext_fall = 1'b0;
        ext_rise = 1'b0;
        sck_fall = 1'b0;
        sck_rise = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        si_now   = 1'b0;
        r_next      = r_reg;
        r_next.done = 1'b0;

        // clock and the input data line enter the port here
        // Pin synchronisers; a level counts once second and third stages agree
        r_next.sck_sync = {r_reg.sck_sync[1:0], i_sck_in};
        r_next.si_sync  = {r_reg.si_sync[1:0], i_si_in};
        if (r_reg.sck_sync[1] == r_reg.sck_sync[2]) begin
            r_next.sck_lvl = r_reg.sck_sync[2];
            ext_fall       = r_reg.sck_lvl && !r_reg.sck_sync[2];
            ext_rise       = !r_reg.sck_lvl && r_reg.sck_sync[2];
        end
        if (r_reg.si_sync[1] == r_reg.si_sync[2]) begin
            r_next.si_lvl = r_reg.si_sync[2];
        end
        // Capture uses the level settling this cycle; the registered copy
        // lags one more cycle, which is an eighth of a bit at the fastest divider
        si_now = r_next.si_lvl;

        // divider runs only inside a transfer, so the line rests high
        if (r_reg.state == TWS_RUN && internal_clk) begin
            if (r_reg.divcnt == half_count(clock_select)) begin
                r_next.divcnt  = '0;
                r_next.sck_int = !r_reg.sck_int;
                sck_fall       = r_reg.sck_int;
                sck_rise       = !r_reg.sck_int;
            end else begin
                r_next.divcnt = r_reg.divcnt + 1'b1;
            end
        end else begin
            r_next.divcnt  = '0;
            r_next.sck_int = 1'b1;
            sck_fall       = !internal_clk && ext_fall;
            sck_rise       = !internal_clk && ext_rise;
        end
        if (r_reg.state == TWS_RUN && !internal_clk) begin
            sck_fall = ext_fall;
            sck_rise = ext_rise;
        end

        // byte write, or single-bit write to mode control
        if (ctrl_wr) begin
            r_next.ctrl = i_cpu_wdata & TWS_CTRL_WMASK;
        end else if (i_cpu_bit_wr && hit(i_cpu_addr, TWS_MODE_CTRL_ADDR)) begin
            r_next.ctrl[i_cpu_bit_idx] = i_cpu_bit_val & TWS_CTRL_WMASK[i_cpu_bit_idx];
        end

        // Register reads; mode 0 blocks shift data reads
        if (i_cpu_rd) begin
            if (hit(i_cpu_addr, TWS_MODE_CTRL_ADDR)) begin
                r_next.rdata = r_reg.ctrl;
            // data read blocked in combined mode
            end else if (data_rd && rx_only_mode) begin
                r_next.rdata = r_reg.sreg;
            end else begin
                r_next.rdata = TWS_BLOCKED_READ;
            end
        end

        // data writes blocked in receive-only mode
        // a write while disabled only loads the register, no start
        if (data_wr && !rx_only_mode) begin
            if (port_enable_bit) begin
                push = !buf_full;
            end else if (r_reg.state == TWS_IDLE) begin
                r_next.sreg = i_cpu_wdata;
            end
        end
        if (push) begin
            r_next.buf_data[r_reg.buf_wptr] = i_cpu_wdata;
            r_next.buf_wptr                 = !r_reg.buf_wptr;
        end

        unique case (r_reg.state)
            TWS_IDLE: begin
                // start from a buffered write in combined mode
                if (port_enable_bit && !rx_only_mode && r_reg.buf_count != 2'h0) begin
                    pop          = 1'b1;
                    r_next.sreg  = r_reg.buf_data[r_reg.buf_rptr];
                    r_next.state = TWS_RUN;
                // receive-only transfer started by a read
                end else if (port_enable_bit && rx_only_mode && data_rd) begin
                    r_next.state = TWS_RUN;
                end
            end
            TWS_RUN: begin
                // shift and drive the next bit on falling edge
                if (sck_fall) begin
                    // written byte leaves through the output latch
                    if (!rx_only_mode) begin
                        r_next.so = r_reg.sreg[TWS_LAST_BIT];
                    end
                    r_next.sreg = {r_reg.sreg[6:0], 1'b0};
                end
                // same shift register carries both directions
                // received bits assemble in the shift register
                if (sck_rise) begin
                    r_next.sreg[0] = si_now;
                    r_next.bitcnt  = r_reg.bitcnt + 1'b1;
                    // stop after the eighth bit and flag completion
                    if (r_reg.bitcnt == TWS_LAST_BIT) begin
                        r_next.state = TWS_IDLE;
                        r_next.done  = 1'b1;
                    end
                end
            end
        endcase

        if (pop) begin
            r_next.buf_rptr = !r_reg.buf_rptr;
        end
        r_next.buf_count = r_reg.buf_count + 2'(push) - 2'(pop);

        // disable stops shifting and clears the bit counter
        if (!port_enable_bit) begin
            r_next.state     = TWS_IDLE;
            r_next.bitcnt    = '0;
            r_next.buf_count = '0;
            r_next.buf_rptr  = r_reg.buf_wptr;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // mode control and everything except the clock synchroniser and clock level clear on reset
    // shift contents clear to zero on reset as well
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg      <= '0;
            r_reg.ctrl <= TWS_CTRL_RESET;
            // Clock pin idles high; matching it avoids a false edge after reset
            r_reg.sck_sync <= '1;
            r_reg.sck_lvl  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // pins join the serial function only as the mode needs them
    assign o_sck_out       = r_reg.sck_int;
    assign o_sck_oe        = port_enable_bit && internal_clk;
    assign o_so_out        = r_reg.so;
    assign o_so_oe         = port_enable_bit && !rx_only_mode;
    assign o_cpu_rdata     = r_reg.rdata;
    assign o_wr_ready      = !buf_full;     // Back-pressure on a full buffer
    assign o_transfer_done = r_reg.done;
    assign o_busy          = (r_reg.state == TWS_RUN);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_disable_clears_count: assert property (
        !port_enable_bit |=> (r_reg.bitcnt == 3'h0) && (r_reg.state == TWS_IDLE))
        else $error("Bit counter not cleared while disabled");

    a_pins_released: assert property (
        !port_enable_bit |-> !o_sck_oe && !o_so_oe)
        else $error("Pin driven while port disabled");

    a_rx_only_no_so: assert property (
        rx_only_mode |-> !o_so_oe)
        else $error("Output pin driven in receive-only mode");

    a_reserved_zero: assert property (
        r_reg.ctrl[6:3] == 4'h0)
        else $error("Reserved control bits not zero");

    a_sck_idles_high: assert property (
        (r_reg.state == TWS_IDLE) |=> o_sck_out)
        else $error("Serial clock not high between transfers");

    a_done_single_pulse: assert property (
        o_transfer_done |-> $past(r_reg.state) == TWS_RUN && !o_busy ##1 !o_transfer_done)
        else $error("Done flag not a single pulse after transfer");

    a_write_starts_run: assert property (
        data_wr && port_enable_bit && !rx_only_mode && !o_busy
        && r_reg.buf_count == 2'h0 |-> ##2 o_busy)
        else $error("Write did not start a transfer");

    a_read_starts_run: assert property (
        data_rd && port_enable_bit && rx_only_mode && !o_busy |=> o_busy)
        else $error("Read did not start a receive");

    a_disabled_write_idle: assert property (
        data_wr && !port_enable_bit |=> !o_busy)
        else $error("Write while disabled started a transfer");

    a_msb_on_fall: assert property (
        o_busy && internal_clk && !rx_only_mode && $fell(o_sck_out)
        |-> o_so_out == $past(r_reg.sreg[TWS_LAST_BIT]))
        else $error("Output bit not the shift MSB at falling edge");

    a_read_blocked: assert property (
        data_rd && !rx_only_mode |=> o_cpu_rdata == TWS_BLOCKED_READ)
        else $error("Data read not blocked in combined mode");

    // eight rising edges wrap the counter back to zero
    a_idle_count_zero: assert property (
        (r_reg.state == TWS_IDLE) |-> (r_reg.bitcnt == 3'h0))
        else $error("Bit counter not zero while idle");

endmodule : tws_serial_port

// file: tws_peer_model.sv
// Far-side peripheral model for the three-wire serial port
module tws_peer_model (
    // Pin side
    input  wire logic       i_sck,
    input  wire logic       i_so,
    output logic            o_si,
    output logic            o_sck,
    // Bench control
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_load,
    input  wire logic       i_ext_go,
    output logic [7:0]      o_rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx_sh = 8'h00;
    int         n_rise = 0;
    initial begin
        o_si = 1'b0;
        o_sck = 1'b1;
        o_rx_byte = 8'h00;
    end
    // Take the next word to send
    always @(posedge i_load) begin
        tx_sh = i_tx_byte;
        n_rise = 0;
    end
    // next bit on falling clock, MSB first
    always @(negedge i_sck) begin
        o_si = tx_sh[7];
        tx_sh = {tx_sh[6:0], 1'b0};
    end
    // capture on rising clock; after the eighth capture, hold time over, line flips
    always @(posedge i_sck) begin
        o_rx_byte = {o_rx_byte[6:0], i_so};
        n_rise = n_rise + 1;
        if (n_rise == 8) begin
            #20 o_si = ~o_si;
        end
    end
    // External clock frame: eight pulses, idle high between frames
    always @(posedge i_ext_go) begin
        repeat (8) begin
            #62.5 o_sck = 1'b0;
            #62.5 o_sck = 1'b1;
        end
    end
endmodule // tws_peer_model

// file: tws_testbench.sv
// Self-checking testbench for the three-wire serial port
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import tws_pkg::*;
    localparam logic [15:0] A_CTRL = TWS_MODE_CTRL_ADDR;
    localparam logic [15:0] A_DATA = TWS_SHIFT_DATA_ADDR;
    logic        core_clk, rst_n, cpu_wr, cpu_rd, bit_wr, bit_val;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, peer_tx, peer_rx, rd_val;
    logic [2:0]  bit_idx;
    logic        wr_ready, done, busy, sck_out, sck_oe, so_out, so_oe, si, peer_sck;
    logic        peer_load, ext_go, sck_line, so_line;
    logic [7:0]  rx_q[$];
    int          n_mismatch = 0, checked = 0, n_done = 0, n_fall = 0, cycles = 0;

    // clock pin follows the port while the port drives it, otherwise the peer clock
    // Pin levels; an undriven output line shows a changing pattern
    assign sck_line = sck_oe ? sck_out : peer_sck;
    assign so_line  = so_oe ? so_out : cycles[0];

    tws_serial_port dut_u (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_cpu_addr(cpu_addr),
        .i_cpu_wr(cpu_wr), .i_cpu_rd(cpu_rd), .i_cpu_wdata(cpu_wdata), .i_cpu_bit_wr(bit_wr),
        .i_cpu_bit_idx(bit_idx), .i_cpu_bit_val(bit_val), .o_cpu_rdata(cpu_rdata),
        .o_wr_ready(wr_ready), .o_transfer_done(done), .o_busy(busy), .i_sck_in(sck_line),
        .o_sck_out(sck_out), .o_sck_oe(sck_oe), .o_so_out(so_out), .o_so_oe(so_oe),
        .i_si_in(si));
    tws_peer_model peer_u (.i_sck(sck_line), .i_so(so_line), .o_si(si), .o_sck(peer_sck),
        .i_tx_byte(peer_tx), .i_load(peer_load), .i_ext_go(ext_go), .o_rx_byte(peer_rx));

    // Clock, pulse bookkeeping and hang guard
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(negedge sck_line) n_fall++;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (done === 1'b1) begin
            n_done <= n_done + 1;
            rx_q.push_back(peer_rx);
        end
        if (cycles == 60000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic acc(input logic w, input logic r, input logic b, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {cpu_wr, cpu_rd, bit_wr} = {w, r, b};
        cpu_addr = a;
        cpu_wdata = d;
        bit_idx = d[2:0];
        bit_val = d[7];
        @(posedge core_clk);
        #1;
        {cpu_wr, cpu_rd, bit_wr} = 3'h0;
        rd_val = cpu_rdata;
    endtask
    // shift data is left alone until the transfer reports done
    task automatic wait_done(input int target);
        for (int k = 0; k < 3000 && n_done < target; k++) @(posedge core_clk);
        #1;
        cmp1("done count", 1'b1, n_done == target);
    endtask
    task automatic peer_send(input logic [7:0] b);
        peer_tx = b;
        peer_load = 1'b1;
        #1 peer_load = 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_ctrl();
        acc(0, 1, 0, A_CTRL, 8'h00);
        cmp8("ctrl reset", 8'h00, rd_val);
        cmp1("pins released", 1'b0, sck_oe | so_oe);
        acc(1, 0, 0, A_CTRL, 8'hFF);
        acc(0, 1, 0, A_CTRL, 8'h00);
        cmp8("ctrl fixed bits", 8'h87, rd_val);
        acc(1, 0, 0, A_CTRL, 8'h00);
        acc(0, 0, 1, A_CTRL, 8'h87);
        acc(0, 0, 1, A_CTRL, 8'h85);
        acc(0, 0, 1, A_CTRL, 8'h81);
        acc(0, 1, 0, A_CTRL, 8'h00);
        cmp8("ctrl bit write", 8'h82, rd_val);
        cmp1("sck driven", 1'b1, sck_oe);
        cmp1("so driven", 1'b1, so_oe);
        $display("test reset_ctrl done");
    endtask
    task automatic t_no_start();
        int f0;
        acc(1, 0, 0, A_CTRL, 8'h01);
        f0 = n_fall;
        acc(1, 0, 0, A_DATA, 8'h5A);
        acc(1, 0, 0, A_CTRL, 8'h81);
        repeat (20) @(posedge core_clk);
        cmp1("busy after late enable", 1'b0, busy);
        cmp1("no clock pulses", 1'b1, n_fall == f0);
        $display("test no_start done");
    endtask
    task automatic t_xfer();
        int f0, c0, span, ratio;
        logic [7:0] tx, in;
        for (int s = 1; s < 4; s++) begin
            ratio = (s == 1) ? 8 : (s == 2) ? 32 : 128;
            tx = 8'hA5 ^ 8'(s << 3);
            in = 8'hC3 ^ 8'(s);
            peer_send(in);
            acc(1, 0, 0, A_CTRL, 8'h80 | 8'(s));
            f0 = n_fall;
            c0 = cycles;
            acc(1, 0, 0, A_DATA, tx);
            wait_done(n_done + 1);
            span = cycles - c0;
            cmp8("peer received", tx, rx_q[$]);
            cmp1("eight falls", 1'b1, n_fall - f0 == 8);
            cmp1("rate", 1'b1, span >= 8 * ratio && span <= 8 * ratio + 8);
            cmp1("idle high", 1'b1, sck_out & ~busy);
            acc(0, 1, 0, A_DATA, 8'h00);
            cmp8("read blocked", 8'h00, rd_val);
            acc(1, 0, 0, A_CTRL, 8'h84 | 8'(s));
            acc(0, 1, 0, A_DATA, 8'h00);
            cmp8("captured byte", in, rd_val);
            cmp1("so released", 1'b0, so_oe);
            wait_done(n_done + 1);
        end
        $display("test xfer done");
    endtask
    task automatic t_ext_rx();
        acc(1, 0, 0, A_CTRL, 8'h84);
        cmp1("sck input", 1'b0, sck_oe);
        acc(1, 0, 0, A_DATA, 8'h3C);
        repeat (10) @(posedge core_clk);
        cmp1("write blocked", 1'b0, busy);
        peer_send(8'h96);
        acc(0, 1, 0, A_DATA, 8'h00);
        repeat (3) @(posedge core_clk);
        cmp1("busy", 1'b1, busy);
        ext_go = 1'b1;
        wait_done(n_done + 1);
        ext_go = 1'b0;
        acc(0, 1, 0, A_DATA, 8'h00);
        cmp8("received byte", 8'h96, rd_val);
        acc(1, 0, 0, A_CTRL, 8'h04);
        // The engine drops back to idle one edge after the write lands
        @(posedge core_clk);
        #1;
        cmp1("abort stops", 1'b0, busy | sck_oe | so_oe);
        $display("test ext_rx done");
    endtask
    task automatic t_buffer();
        int n, d0;
        n = 0;
        d0 = n_done;
        rx_q.delete();
        acc(1, 0, 0, A_CTRL, 8'h81);
        while (wr_ready === 1'b1 && n < 4) begin
            acc(1, 0, 0, A_DATA, 8'(8'h11 * (n + 1)));
            n++;
        end
        acc(1, 0, 0, A_DATA, 8'hEE);
        cmp1("buffer refuses", 1'b1, n >= 2 && wr_ready === 1'b0);
        wait_done(d0 + n);
        repeat (200) @(posedge core_clk);
        cmp1("no extra word", 1'b1, n_done == d0 + n);
        for (int k = 0; k < n; k++) begin
            cmp8("buffered word", 8'(8'h11 * (k + 1)), rx_q[k]);
        end
        cmp1("ready again", 1'b1, wr_ready);
        $display("test buffer done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {rst_n, cpu_wr, cpu_rd, bit_wr, bit_val, peer_load, ext_go} = 7'h00;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        bit_idx = 3'h0;
        peer_tx = 8'h00;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_reset_ctrl();
        t_no_start();
        t_xfer();
        t_ext_rx();
        t_buffer();
        end_of_test();
    end
endmodule // testbench
